// *** hdl/fabric_datapath.v ***
// Summary of operation
// (R1) tx core clock writes tx fifo
// (R2) integrator enables tx core clock when needed
// (R3) rx core clock reads rx fifo; the code keeps it off on the highest rate path
// (R4) integrator enables rx core clock when needed
// (R5) tx slip before gearbox, max width-1; the slipper caps it at 31 when width is above 32
// (R6) five-bit slip count per lane
// (R7) slip one uses previous bit 63 lsb
// (R8) tx slip absent on highest rate path
// (R9) rx slip puts aligner in slip mode; the code gives slip mode on the 10g path only
// (R10) embedded reset on by default, edge start
// (R11) disabled: external resets, no ready outputs
// (R12) symbol order option reorders bytes
// (R13) one to four plls, lane selects
// (R14) integrator disables embedded reset for multi-pll
// (R15) five refclocks, per-pll index 0-4
// (R16) main pll index selects startup pll
// (R17) cdr input clock index 0-3
// (R18) pll output is base rate halved
// (R19) standard reconfig: tx 44, rx 64
// (R20) 10g reconfig: both buses 64
// (R21) integrator enables pll reconfig first
// (R22) management reset async active high level
// (R23) tx ready after leaving reset
// (R24) zero ready latency on data paths
// (R25) slip change only on word boundary
//
// fabric-side datapath of one lane: fifo clock selection, tx slip,
// symbol ordering, reset sequencer and pll selection
// assumes all pins synchronous to clk_sys except mgmt_reset
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "fabric_datapath_map.vh"
module fabric_datapath #(
  parameter DATAPATH = `DP_TENG,
  parameter W = 64,
  parameter NUM_PLL = 4,
  parameter NUM_REF = 5,
  parameter RECONFIG = 1
) (
  // clock and reset
  input wire clk_sys,
  input wire arst_n,
  input wire mgmt_reset,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  // optional core clock use flags
  input wire tx_coreclk_en,
  input wire rx_coreclk_en,
  output wire tx_fifo_wr_user_clk,
  output wire rx_fifo_rd_user_clk,
  // external reset inputs when embedded control is off
  input wire ext_pll_powerdown,
  input wire ext_tx_analog_rst,
  input wire ext_tx_digital_rst,
  input wire ext_rx_analog_rst,
  input wire ext_rx_digital_rst,
  // reset outputs to pma/pcs
  output wire pll_powerdown,
  output wire tx_analog_rst,
  output wire tx_digital_rst,
  output wire rx_analog_rst,
  output wire rx_digital_rst,
  output wire tx_ready,
  output wire rx_ready,
  // tx path
  input wire [4:0] tx_slip_count,
  input wire [63:0] tx_parallel_in,
  output reg [63:0] tx_to_gearbox_q,
  // rx path
  input wire [63:0] rx_from_pcs,
  output reg [63:0] rx_parallel_out_q,
  output wire rx_aligner_slip_mode,
  // pll and clock selection
  output wire [3:0] tx_pll_onehot,
  output wire [2:0] active_pll_ref,
  output wire [1:0] cdr_ref_sel,
  output wire [1:0] pll_base_mult_log2
);
  localparam TXW = (DATAPATH == `DP_STANDARD && RECONFIG) ? 44 : 64;
  localparam RXW = 64;
  localparam FW = (W < TXW) ? W : TXW;
  localparam SLIP_OK = (DATAPATH != `DP_HIGHEST);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_PLL = 4'b0010;
  localparam [3:0] ST_ANALOG = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg [3:0] ctrl_q;
  reg [1:0] main_pll_q;
  reg [1:0] cdr_sel_q;
  reg [1:0] rate_q;
  reg [11:0] pll_ref_q;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [7:0] cnt_q;
  reg mr_s1_q;
  reg mr_s2_q;
  reg mr_s3_q;
  reg start_q;
  wire embed;
  wire mr_rise;
  wire [63:0] slipped;
  wire [63:0] tx_sym;
  wire [63:0] rx_sym;
  wire [FW-1:0] tx_field;
  wire step_done;

  assign embed = ctrl_q[`CTRL_RST_EMBED];

  // core clock flags: the fifo side follows the user clock when enabled, for rx except on the highest rate path
  assign tx_fifo_wr_user_clk = tx_coreclk_en; // [R1]
  assign rx_fifo_rd_user_clk = rx_coreclk_en & (DATAPATH != `DP_HIGHEST); // [R3]

  // mgmt reset is async, so it is synchronised before edge detection
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mr_s1_q <= 1'b0;
      mr_s2_q <= 1'b0;
      mr_s3_q <= 1'b0;
    end
    else
    begin
      mr_s1_q <= mgmt_reset; // [R22]
      mr_s2_q <= mr_s1_q;
      mr_s3_q <= mr_s2_q;
    end
  end
  assign mr_rise = mr_s2_q & ~mr_s3_q; // [R10]

  // registers written by software
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= `CTRL_RESET_VAL; // [R10]
      main_pll_q <= 2'h0;
      cdr_sel_q <= 2'h0;
      rate_q <= 2'h0;
      pll_ref_q <= 12'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `REG_CTRL)
        ctrl_q <= reg_wdata[3:0];
      else if (reg_addr == `REG_PLL_SEL)
      begin
        // out-of-range pll indices fall back to pll 0
        main_pll_q <= (reg_wdata[`PLLSEL_MAIN_LSB+:2] < NUM_PLL) ? reg_wdata[`PLLSEL_MAIN_LSB+:2] : 2'h0; // [R16] [R13]
        cdr_sel_q <= reg_wdata[`PLLSEL_CDR_LSB+:2]; // [R17]
        rate_q <= reg_wdata[`PLLSEL_RATE_LSB+:2]; // [R18]
      end
      else if (reg_addr == `REG_PLL_REF)
        pll_ref_q <= reg_wdata[11:0];
    end
  end

  // read port: data in the cycle after the strobe, unmapped reads zero
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata_q <= 32'h0;
    else if (reg_rd)
    begin
      if (reg_addr == `REG_CTRL)
        reg_rdata_q <= {28'h0, ctrl_q};
      else if (reg_addr == `REG_PLL_SEL)
        reg_rdata_q <= {22'h0, rate_q, 2'h0, cdr_sel_q, 2'h0, main_pll_q};
      else if (reg_addr == `REG_STATUS)
        reg_rdata_q <= {28'h0, state_q};
      else if (reg_addr == `REG_SLIP)
        reg_rdata_q <= {27'h0, tx_slip_count};
      else if (reg_addr == `REG_PLL_REF)
        reg_rdata_q <= {20'h0, pll_ref_q};
      else
        reg_rdata_q <= 32'h0;
    end
    else
      reg_rdata_q <= 32'h0;
  end

  // embedded reset sequencer, restarted by every mgmt reset rising edge
  assign step_done = (cnt_q == `RST_STEP_CYC - 1);
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: state_d = ST_PLL;
      ST_PLL: if (step_done) state_d = ST_ANALOG;
      ST_ANALOG: if (step_done) state_d = ST_DONE;
      ST_DONE: state_d = ST_DONE;
      default: state_d = ST_IDLE;
    endcase
    if (start_q)
      state_d = ST_IDLE; // [R10]
  end

  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h0;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= mr_rise;
      state_q <= state_d;
      cnt_q <= (state_d != state_q || step_done) ? 8'h0 : cnt_q + 8'h1;
    end
  end

  // reset outputs: sequencer when embedded, else external pins pass through
  assign pll_powerdown = embed ? state_q[0] : ext_pll_powerdown; // [R11]
  assign tx_analog_rst = embed ? (state_q[0] | state_q[1]) : ext_tx_analog_rst; // [R11]
  assign rx_analog_rst = embed ? (state_q[0] | state_q[1]) : ext_rx_analog_rst;
  assign tx_digital_rst = embed ? ~state_q[3] : ext_tx_digital_rst;
  assign rx_digital_rst = embed ? ~state_q[3] : ext_rx_digital_rst;
  // ready is absent (held low) when resets are external
  assign tx_ready = embed & state_q[3]; // [R23] [R11]
  assign rx_ready = embed & state_q[3]; // [R24]

  // tx path: slip only on standard and 10g paths
  tx_bit_slipper #(
    .W(FW)
  ) u_slip (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .enable(ctrl_q[`CTRL_TX_SLIP] & SLIP_OK), // [R8]
    .slip(tx_slip_count), // [R6]
    .din(tx_field),
    .dout_q(slipped[FW-1:0])
  );
  // only the low fabric-width bits are carried
  assign tx_field = tx_parallel_in[FW-1:0]; // [R19] [R20]
  generate
    if (FW < 64)
    begin : g_pad
      assign slipped[63:FW] = {(64-FW){1'b0}};
    end
  endgenerate

  // symbol order option reverses byte order across the whole 64-bit word
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1)
    begin : g_sym
      assign tx_sym[8*b+:8] = slipped[8*(7-b)+:8];
      assign rx_sym[8*b+:8] = rx_from_pcs[8*(7-b)+:8];
    end
  endgenerate

  // data outputs registered; zero ready latency means no stall path
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_to_gearbox_q <= 64'h0;
      rx_parallel_out_q <= 64'h0;
    end
    else
    begin
      tx_to_gearbox_q <= ctrl_q[`CTRL_SYM_ORDER] ? tx_sym : slipped; // [R12] [R5]
      rx_parallel_out_q <= ctrl_q[`CTRL_SYM_ORDER] ? rx_sym : rx_from_pcs; // [R12] [R24]
    end
  end

  // aligner slip mode exists only on the 10g path
  assign rx_aligner_slip_mode = ctrl_q[`CTRL_RX_SLIP] & (DATAPATH == `DP_TENG); // [R9]

  // pll selection: one-hot active pll and its reference index
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1)
    begin : g_pll
      assign tx_pll_onehot[p] = (main_pll_q == p) && (p < NUM_PLL); // [R13] [R16]
    end
  endgenerate
  // reference indices at or above the configured count clamp to zero
  assign active_pll_ref = (pll_ref_q[3*main_pll_q+:3] < NUM_REF) ? pll_ref_q[3*main_pll_q+:3] : 3'h0; // [R15]
  assign cdr_ref_sel = cdr_sel_q; // [R17]
  // base rate multiplier as log2 (1,2,4,8); output clock is base/2
  assign pll_base_mult_log2 = rate_q; // [R18]
endmodule // fabric_datapath
`default_nettype wire

// *** hdl/fabric_datapath_map.vh ***
// constants for the fabric-side transceiver datapath block
// assumes a 100 MHz system clock; included by bare name
`ifndef FABRIC_DATAPATH_MAP_VH
`define FABRIC_DATAPATH_MAP_VH
// datapath kinds
`define DP_STANDARD 2'd0
`define DP_TENG 2'd1
`define DP_HIGHEST 2'd2
// register offsets
`define REG_CTRL 4'h0
`define REG_PLL_SEL 4'h1
`define REG_STATUS 4'h2
`define REG_SLIP 4'h3
`define REG_PLL_REF 4'h4
// control register fields
`define CTRL_RST_EMBED 0
`define CTRL_SYM_ORDER 1
`define CTRL_RX_SLIP 2
`define CTRL_TX_SLIP 3
`define CTRL_RESET_VAL 4'h1
// pll select fields
`define PLLSEL_MAIN_LSB 0
`define PLLSEL_CDR_LSB 4
`define PLLSEL_RATE_LSB 8
// reset sequence step time in ns and cycles at 10 ns
`define RST_STEP_NS 100
`define CLK_PERIOD_NS 10
`define RST_STEP_CYC (`RST_STEP_NS / `CLK_PERIOD_NS)
`define SLIP_W 5
`endif

// *** hdl/tx_bit_slipper.v ***
// one-lane transmit bit slip ahead of the gearbox
// assumes words arrive each clock; slip count is registered here
`timescale 1ns/10ps
`default_nettype none
module tx_bit_slipper #(
  parameter W = 64
) (
  // clock and reset
  input wire clk_sys,
  input wire arst_n,
  // control
  input wire enable,
  input wire [4:0] slip,
  // data
  input wire [W-1:0] din,
  output reg [W-1:0] dout_q
);
  reg [W-1:0] prev_q;
  reg [4:0] slip_q;
  wire [2*W-1:0] pair;
  wire [2*W-1:0] shifted;
  wire [4:0] slip_lim;
  // largest legal slip, also bounded by what five count bits can hold
  localparam [31:0] SLIP_MAX_I = (W > 32) ? 31 : W - 1;

  // clamp to width minus one, or to 31 above 32 bits, so the window never leaves the pair
  assign slip_lim = (slip > SLIP_MAX_I) ? SLIP_MAX_I[4:0] : slip; // [R5]
  assign pair = {din, prev_q};
  // slip n takes low n bits from the previous word's top
  assign shifted = pair >> (W - slip_q); // [R7]

  // slip applies only on word boundary, one register stage
  always @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_q <= {W{1'b0}};
      slip_q <= 5'h0;
      dout_q <= {W{1'b0}};
    end
    else
    begin
      prev_q <= din;
      slip_q <= enable ? slip_lim : 5'h0; // [R25] [R6]
      dout_q <= (slip_q == 5'h0) ? din : shifted[W-1:0]; // [R5]
    end
  end
endmodule // tx_bit_slipper
`default_nettype wire

// *** tb/fabric_datapath_props.sv ***
// port assertions for the fabric datapath block
// assumes one clock domain; bound into every fabric_datapath
`timescale 1ns/10ps
`default_nettype none
`include "fabric_datapath_map.vh"
module fabric_datapath_props #(
  parameter DATAPATH = `DP_TENG
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic mgmt_reset,
  // clock use and reset state
  input wire logic tx_coreclk_en,
  input wire logic rx_coreclk_en,
  input wire logic tx_fifo_wr_user_clk,
  input wire logic rx_fifo_rd_user_clk,
  input wire logic tx_ready,
  input wire logic pll_powerdown,
  input wire logic tx_digital_rst,
  // data and pll select
  input wire logic [4:0] tx_slip_count,
  input wire logic [63:0] tx_parallel_in,
  input wire logic [63:0] tx_to_gearbox_q,
  input wire logic [63:0] rx_from_pcs,
  input wire logic [63:0] rx_parallel_out_q,
  input wire logic [3:0] tx_pll_onehot
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  // byte swapped copy, the other legal rx word
  wire [63:0] rx_rev = {<<8{rx_from_pcs}};
  tx_clk_use_a: assert property (tx_fifo_wr_user_clk == tx_coreclk_en) else $error("tx clk use");
  rx_clk_use_a: assert property (rx_fifo_rd_user_clk == (rx_coreclk_en && DATAPATH != `DP_HIGHEST))
    else $error("rx clk use");
  restart_drop_a: assert property ($rose(mgmt_reset) |-> ##[1:8] !tx_ready) else $error("no restart");
  ready_clean_a: assert property (tx_ready |-> !pll_powerdown && !tx_digital_rst) else $error("ready in rst");
  pll_onehot_a: assert property ($onehot(tx_pll_onehot)) else $error("pll sel");
  main_start_a: assert property ($rose(arst_n) |-> tx_pll_onehot == 4'h1) else $error("start pll");
  // a zero slip on a steady word must pass it through unchanged
  zero_slip_a: assert property ((tx_slip_count == 5'h0 && $stable(tx_parallel_in))[*3]
    |=> tx_to_gearbox_q == $past(tx_parallel_in)) else $error("zero slip");
  rx_word_a: assert property (1'b1 |=> rx_parallel_out_q == $past(rx_from_pcs)
    || rx_parallel_out_q == $past(rx_rev)) else $error("rx word");
  cover property ($rose(tx_ready));
  cover property (tx_pll_onehot == 4'h8);
  cover property (tx_slip_count == 5'h1f);
endmodule // fabric_datapath_props
bind fabric_datapath fabric_datapath_props #(.DATAPATH(DATAPATH)) props_u (.*);
`default_nettype wire

// *** tb/mac_model.sv ***
// fabric mac stand-in: sends one tx word every edge
// assumes the scenario sets the next word; fixed 10g 64:32 ratio
`timescale 1ns/10ps
`default_nettype none
module mac_model #(
  parameter FABRIC_W = 64,
  parameter PCS_W = 32
) (
  // clock
  input wire logic clk_sys,
  // word to send
  input wire logic [63:0] next_word,
  // to the block
  output logic [63:0] tx_word_q,
  output logic tx_coreclk_en,
  output logic rx_coreclk_en
);
  // user core clocks are mandatory at 50:40 and at 64:32
  assign tx_coreclk_en = (FABRIC_W == 50 && PCS_W == 40) || (FABRIC_W == 64 && PCS_W == 32);
  assign rx_coreclk_en = (FABRIC_W == 50 && PCS_W == 40) || (FABRIC_W == 64 && PCS_W == 32);
  // no back pressure: data flows from the first edge after reset
  always @(posedge clk_sys)
    tx_word_q <= next_word;
endmodule // mac_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the fabric datapath block
// assumes the mac model feeds tx words and core clock flags
`timescale 1ns/10ps
`default_nettype none
`include "fabric_datapath_map.vh"
module tb;
  logic clk_sys, arst_n, mgmt_reset, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [4:0] ext_rst, tx_slip_count;
  logic [63:0] next_word, rx_from_pcs;
  wire [31:0] reg_rdata_q;
  wire [63:0] tx_word, tx_to_gearbox_q, rx_parallel_out_q;
  wire tx_coreclk_en, rx_coreclk_en, tx_fifo_wr_user_clk, rx_fifo_rd_user_clk, tx_ready, rx_ready, rx_slip_mode;
  wire [4:0] rst_out;
  wire [3:0] tx_pll_onehot;
  wire [2:0] active_pll_ref;
  wire [1:0] cdr_ref_sel, pll_base_mult_log2;
  int failures, n_compared;
  // reconfiguration channel left on, as the integrator must before pll changes
  fabric_datapath #(
    .RECONFIG(1)
  ) dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .mgmt_reset(mgmt_reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .tx_coreclk_en(tx_coreclk_en),
    .rx_coreclk_en(rx_coreclk_en), .tx_fifo_wr_user_clk(tx_fifo_wr_user_clk),
    .rx_fifo_rd_user_clk(rx_fifo_rd_user_clk), .ext_pll_powerdown(ext_rst[4]), .ext_tx_analog_rst(ext_rst[3]),
    .ext_tx_digital_rst(ext_rst[2]), .ext_rx_analog_rst(ext_rst[1]), .ext_rx_digital_rst(ext_rst[0]),
    .pll_powerdown(rst_out[4]), .tx_analog_rst(rst_out[3]), .tx_digital_rst(rst_out[2]),
    .rx_analog_rst(rst_out[1]), .rx_digital_rst(rst_out[0]), .tx_ready(tx_ready), .rx_ready(rx_ready),
    .tx_slip_count(tx_slip_count), .tx_parallel_in(tx_word), .tx_to_gearbox_q(tx_to_gearbox_q),
    .rx_from_pcs(rx_from_pcs), .rx_parallel_out_q(rx_parallel_out_q), .rx_aligner_slip_mode(rx_slip_mode),
    .tx_pll_onehot(tx_pll_onehot), .active_pll_ref(active_pll_ref), .cdr_ref_sel(cdr_ref_sel),
    .pll_base_mult_log2(pll_base_mult_log2)
  );
  mac_model mac_u (
    .clk_sys(clk_sys), .next_word(next_word), .tx_word_q(tx_word), .tx_coreclk_en(tx_coreclk_en),
    .rx_coreclk_en(rx_coreclk_en)
  );
  // 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata_q, exp);
  endtask
  function automatic logic [63:0] rotl(input logic [63:0] w, input int n);
    return (w << n) | (w >> (64 - n));
  endfunction
  task automatic t_regs;
    rd(`REG_CTRL, 32'h1);
    check(tx_fifo_wr_user_clk, tx_coreclk_en);
    check(rx_fifo_rd_user_clk, rx_coreclk_en);
    for (int i = 0; i < 4; i++)
    begin
      wr(`REG_PLL_SEL, 32'h320 | i);
      tick(1);
      check(tx_pll_onehot, 4'h1 << i);
    end
    check(cdr_ref_sel, 2'h2);
    check(pll_base_mult_log2, 2'h3);
    rd(`REG_PLL_SEL, 32'h323);
    wr(`REG_PLL_REF, 32'h800);
    tick(1);
    check(active_pll_ref, 3'h4);
    wr(`REG_PLL_REF, 32'ha00);
    rd(`REG_PLL_REF, 32'ha00);
    check(active_pll_ref, 3'h0);
    rd(4'hf, 32'h0);
    $display("regs done");
  endtask
  // restart from a short management reset pulse, timed from its rise
  task automatic t_restart;
    int n;
    @(posedge clk_sys);
    mgmt_reset <= 1'b1;
    tick(2);
    mgmt_reset <= 1'b0;
    tick(6);
    check(tx_ready, 1'b0);
    n = 8;
    while (tx_ready !== 1'b1 && n < 60)
    begin
      tick(1);
      n++;
    end
    check(n >= 21 && n <= 30, 1'b1);
    check(rx_ready, 1'b1);
    check(rst_out, 5'h0);
    $display("restart done");
  endtask
  task automatic t_slip;
    logic [63:0] a = 64'h8123_4567_89ab_cdef;
    logic [63:0] b = 64'h0fed_cba9_8765_4321;
    int sl[3] = '{0, 31, 1};
    logic hit = 1'b0;
    wr(`REG_CTRL, 32'h9);
    foreach (sl[k])
    begin
      @(posedge clk_sys);
      tx_slip_count <= 5'(sl[k]);
      next_word <= a;
      tick(5);
      check(tx_to_gearbox_q, rotl(a, sl[k]));
    end
    @(posedge clk_sys);
    next_word <= b;
    repeat (6)
    begin
      tick(1);
      if (tx_to_gearbox_q === {b[62:0], a[63]})
        hit = 1'b1;
    end
    check(hit, 1'b1);
    $display("slip done");
  endtask
  task automatic t_rx;
    wr(`REG_CTRL, 32'hd);
    rx_from_pcs <= 64'h0011_2233_4455_6677;
    tick(2);
    check(rx_slip_mode, 1'b1);
    check(rx_parallel_out_q, 64'h0011_2233_4455_6677);
    wr(`REG_CTRL, 32'hb);
    tick(2);
    check(rx_slip_mode, 1'b0);
    check(rx_parallel_out_q, 64'h7766_5544_3322_1100);
    check(tx_to_gearbox_q, {<<8{rotl(64'h0fed_cba9_8765_4321, 1)}});
    $display("rx done");
  endtask
  // embedded control off: resets follow the external pins
  task automatic t_ext;
    wr(`REG_CTRL, 32'h0);
    ext_rst <= 5'h15;
    tick(1);
    check(rst_out, 5'h15);
    check({tx_ready, rx_ready}, 2'h0);
    @(posedge clk_sys);
    ext_rst <= 5'h0a;
    tick(1);
    check(rst_out, 5'h0a);
    $display("ext done");
  endtask
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // watchdog: the tests need well under 1000 cycles
  initial
  begin
    #20000;
    failures++;
    close_out;
  end
  initial
  begin
    failures = 0;
    n_compared = 0;
    arst_n = 1'b0;
    mgmt_reset = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    ext_rst = 5'h0;
    tx_slip_count = 5'h0;
    next_word = 64'h0;
    rx_from_pcs = 64'h0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs;
    t_restart;
    t_slip;
    t_rx;
    t_ext;
    close_out;
  end
endmodule // tb
`default_nettype wire
